/* loop_map.svh */
// constants of the loop control
`ifndef LOOP_MAP_SVH
`define LOOP_MAP_SVH
// How it works
// - reset and command start a six second test; lamp red, then green on pass
// - failing test lights ais for ram, oof for nvram, los for rom
// - starting the test clears the loop and the pass and refused flags, and keeps the fail flags
// - traffic and carrier are halted while the test runs
// - exactly four near loops: line, payload, framed terminal, terminal port
// - line loop returns raw received network signal, framer bypassed
// - line or payload loop stops receive forwarding and drops cts and dcd
// - payload loop returns the framer output to the network
// - framed terminal loop returns framed terminal data to terminal and network
// - terminal port loop returns terminal data straight back
// - far end may only set or clear line and payload loops
// - only one loop at a time; new set refused while one is active
// - far loops set, or cleared by far release command, only under c-bit parity framing
// - received far codes set and release line or payload loop
// - wheel 4 to 7 with apply button selects the four near loops
// - wheel 1 and 2 with apply button request far line and payload loop
// - wheel 0 with apply button clears the active loop
// - register commands act only with maintenance privilege or above
// - a command clears the active near loop
// - commands request far line, far payload and far release
// - all-ones alarm on the received signal lights the ais lamp

// register byte offsets
`define CMD_OFS         8'h00
`define CFG_OFS         8'h04
`define STATUS_OFS      8'h08
// command bits
`define CMD_TEST_BIT    0
`define CMD_CLR_BIT     1
`define CMD_FLINE_BIT   2
`define CMD_FPAY_BIT    3
`define CMD_FCLR_BIT    4
`define CMD_NLINE_BIT   5
`define CMD_NPAY_BIT    6
`define CMD_TFRM_BIT    7
`define CMD_TPORT_BIT   8
// configuration fields and reset values
`define CFG_FRAME_LSB   0
`define CFG_PRIV_LSB    4
`define FRAME_CBIT      2'h0
`define FRAME_M13       2'h1
`define FRAME_E3        2'h2
`define PRIV_NONE       2'h0
`define FRAME_RST       2'h0
`define PRIV_RST        2'h0
// status fields
`define ST_LOOP_LSB     0
`define ST_BUSY_BIT     3
`define ST_PASS_BIT     4
`define ST_RAM_BIT      5
`define ST_NV_BIT       6
`define ST_ROM_BIT      7
`define ST_REJ_BIT      8
// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// wheel positions
`define WHEEL_CLR       4'h0
`define WHEEL_FLINE     4'h1
`define WHEEL_FPAY      4'h2
`define WHEEL_NLINE     4'h4
`define WHEEL_NPAY      4'h5
`define WHEEL_TFRM      4'h6
`define WHEEL_TPORT     4'h7
// timing
`define CLK_KHZ         25000
`define SELF_TEST_MS    6000
`define DEBOUNCE_MS     10
`endif

/* loop_pkg.sv */
// types shared by the loop and self-test control
package loop_pkg;
  typedef enum logic [2:0] {
    loop_none, net_line_loop, net_payload_loop, terminal_framed_loop,
    terminal_port_loop, far_line_loop, far_payload_loop
  } loop_e;
  typedef enum logic [3:0] {
    op_none, op_test, op_denied, op_set, op_set_remote,
    op_clr_local, op_clr_far, op_clr_any, op_clr_remote
  } op_e;
  typedef enum logic {test_idle, test_run} test_e;
endpackage

/* button_debounce.sv */
// debounced apply button
`timescale 1ns/1ns
`default_nettype none
module button_debounce #(
  parameter int unsigned STABLE_CYCLES = 250000
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // raw pin and clean press
  input  wire logic button_pin,
  output logic      press
);
  logic        s1_reg, s2_reg, s1_next, s2_next;
  logic        level_reg, level_next;
  logic        press_reg, press_next;
  logic [31:0] cnt_reg, cnt_next;

  always_comb begin
    s1_next    = button_pin;
    s2_next    = s1_reg;
    level_next = level_reg;
    press_next = 1'b0;
    cnt_next   = 32'h0;
    // a new level must hold for the whole window before it counts
    if (s2_reg != level_reg) begin
      cnt_next = cnt_reg + 32'h1;
      if (cnt_reg == 32'(STABLE_CYCLES - 1)) begin
        level_next = s2_reg;
        press_next = s2_reg;
        cnt_next   = 32'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      level_reg <= 1'b0;
      press_reg <= 1'b0;
      cnt_reg   <= 32'h0;
    end else begin
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      level_reg <= level_next;
      press_reg <= press_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign press = press_reg;
endmodule
`default_nettype wire

/* loop_selftest_ctrl.sv */
// loopback selection and self-test control with an axi4-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "loop_map.svh"
module loop_selftest_ctrl #(
  parameter int unsigned SELF_TEST_CYCLES = `SELF_TEST_MS * `CLK_KHZ,
  parameter int unsigned DEBOUNCE_CYCLES  = `DEBOUNCE_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // front panel pins
  input  wire logic [3:0]  thumbwheel,
  input  wire logic        wheel_apply_button,
  // self-test outcomes
  input  wire logic        ram_test_fail,
  input  wire logic        nvram_test_fail,
  input  wire logic        rom_checksum_fail,
  // network framer status
  input  wire logic        ais_detect,
  input  wire logic        far_line_set_code,
  input  wire logic        far_payload_set_code,
  input  wire logic        far_reset_code,
  // far-end code transmit requests
  output logic             far_line_code_send,
  output logic             far_payload_code_send,
  output logic             far_release_send,
  // data streams
  input  wire logic        net_rx_raw,
  input  wire logic        net_rx_framed,
  input  wire logic        normal_net_tx,
  input  wire logic        term_tx_data,
  input  wire logic        term_framed_data,
  input  wire logic        normal_term_rx,
  output logic             net_tx_data,
  output logic             term_rx_data,
  output logic             cts,
  output logic             dcd,
  output logic             service_halt,
  // lamps
  output logic             status_green,
  output logic             status_red,
  output logic             ais_lamp,
  output logic             oof_lamp,
  output logic             los_lamp
);
  // bus slave state
  logic        awv_reg, awv_next, wv_reg, wv_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] wdat_reg, wdat_next;
  logic [3:0]  wstb_reg, wstb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  frame_reg, frame_next, priv_reg, priv_next;
  logic        do_wr, cmd_wr;
  logic [8:0]  cmd_bits;
  // control state
  loop_pkg::test_e state_reg, state_next;
  loop_pkg::loop_e loop_reg, loop_next, kind;
  loop_pkg::op_e   op;
  logic [31:0] count_reg, count_next;
  logic        pass_reg, pass_next, rej_reg, rej_next;
  logic        ram_reg, ram_next, nv_reg, nv_next, rom_reg, rom_next;
  logic        fl_reg, fl_next, fp_reg, fp_next, fr_reg, fr_next;
  logic        cbit, far_kind;
  // pins and data path
  logic [3:0]  wheel_s1_reg, wheel_s2_reg;
  logic        press;
  logic        ntx_reg, ntx_next, trx_reg, trx_next, car_reg, car_next;
  logic        ais_reg, ais_next;

  // panel button
  // debounced single press
  button_debounce #(
    .STABLE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .button_pin (wheel_apply_button),
    .press      (press)
  );

  assign do_wr    = awv_reg && wv_reg && !bvalid_reg;
  assign cmd_wr   = do_wr && (waddr_reg == `CMD_OFS);
  assign cmd_bits = wdat_reg[8:0] & {wstb_reg[1], {8{wstb_reg[0]}}};

  // bus slave next state
  always_comb begin
    awv_next    = awv_reg;
    wv_next     = wv_reg;
    waddr_next  = waddr_reg;
    wdat_next   = wdat_reg;
    wstb_next   = wstb_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    frame_next  = frame_reg;
    priv_next   = priv_reg;
    if (awvalid && !awv_reg) begin
      awv_next   = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && !wv_reg) begin
      wv_next   = 1'b1;
      wdat_next = wdata;
      wstb_next = wstrb;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (do_wr) begin
      awv_next    = 1'b0;
      wv_next     = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `RESP_OKAY;
      unique case (waddr_reg)
        `CMD_OFS: ;
        `CFG_OFS: begin
          if (wstb_reg[0]) begin
            frame_next = wdat_reg[`CFG_FRAME_LSB +: 2];
            priv_next  = wdat_reg[`CFG_PRIV_LSB +: 2];
          end
        end
        `STATUS_OFS: ;
        default: bresp_next = `RESP_SLVERR;
      endcase
    end
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      rdata_next  = 32'h0;
      unique case (araddr)
        `CMD_OFS: ;
        `CFG_OFS: begin
          rdata_next[`CFG_FRAME_LSB +: 2] = frame_reg;
          rdata_next[`CFG_PRIV_LSB +: 2]  = priv_reg;
        end
        `STATUS_OFS: begin
          rdata_next[`ST_LOOP_LSB +: 3] = loop_reg;
          rdata_next[`ST_BUSY_BIT]      = (state_reg == loop_pkg::test_run);
          rdata_next[`ST_PASS_BIT]      = pass_reg;
          rdata_next[`ST_RAM_BIT]       = ram_reg;
          rdata_next[`ST_NV_BIT]        = nv_reg;
          rdata_next[`ST_ROM_BIT]       = rom_reg;
          rdata_next[`ST_REJ_BIT]       = rej_reg;
        end
        default: rresp_next = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_reg    <= 1'b0;
      wv_reg     <= 1'b0;
      waddr_reg  <= 8'h00;
      wdat_reg   <= 32'h0;
      wstb_reg   <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= `RESP_OKAY;
      rdata_reg  <= 32'h0;
      frame_reg  <= `FRAME_RST;
      priv_reg   <= `PRIV_RST;
    end else begin
      awv_reg    <= awv_next;
      wv_reg     <= wv_next;
      waddr_reg  <= waddr_next;
      wdat_reg   <= wdat_next;
      wstb_reg   <= wstb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      frame_reg  <= frame_next;
      priv_reg   <= priv_next;
    end
  end

  assign awready = !awv_reg;
  assign wready  = !wv_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

  assign cbit     = (frame_reg == `FRAME_CBIT);
  assign far_kind = (kind == loop_pkg::far_line_loop) ||
                    (kind == loop_pkg::far_payload_loop);

  // request source selection, registers first
  always_comb begin
    op   = loop_pkg::op_none;
    kind = loop_pkg::loop_none;
    if (cmd_wr && (cmd_bits != 9'h000)) begin
      if (priv_reg == `PRIV_NONE) begin
        op = loop_pkg::op_denied;
      end else if (cmd_bits[`CMD_TEST_BIT]) begin
        op = loop_pkg::op_test;
      end else if (cmd_bits[`CMD_CLR_BIT]) begin
        op = loop_pkg::op_clr_local;
      end else if (cmd_bits[`CMD_FLINE_BIT]) begin
        op   = loop_pkg::op_set;
        kind = loop_pkg::far_line_loop;
      end else if (cmd_bits[`CMD_FPAY_BIT]) begin
        op   = loop_pkg::op_set;
        kind = loop_pkg::far_payload_loop;
      end else if (cmd_bits[`CMD_FCLR_BIT]) begin
        op = loop_pkg::op_clr_far;
      end else if (cmd_bits[`CMD_NLINE_BIT]) begin
        op   = loop_pkg::op_set;
        kind = loop_pkg::net_line_loop;
      end else if (cmd_bits[`CMD_NPAY_BIT]) begin
        op   = loop_pkg::op_set;
        kind = loop_pkg::net_payload_loop;
      end else if (cmd_bits[`CMD_TFRM_BIT]) begin
        op   = loop_pkg::op_set;
        kind = loop_pkg::terminal_framed_loop;
      end else begin
        op   = loop_pkg::op_set;
        kind = loop_pkg::terminal_port_loop;
      end
    end else if (press) begin
      op = loop_pkg::op_set;
      unique case (wheel_s2_reg)
        `WHEEL_CLR:   op   = loop_pkg::op_clr_any;
        `WHEEL_FLINE: kind = loop_pkg::far_line_loop;
        `WHEEL_FPAY:  kind = loop_pkg::far_payload_loop;
        `WHEEL_NLINE: kind = loop_pkg::net_line_loop;
        `WHEEL_NPAY:  kind = loop_pkg::net_payload_loop;
        `WHEEL_TFRM:  kind = loop_pkg::terminal_framed_loop;
        `WHEEL_TPORT: kind = loop_pkg::terminal_port_loop;
        default:      op   = loop_pkg::op_none;
      endcase
    end else if (far_line_set_code) begin
      // far codes reach only line and payload
      op   = loop_pkg::op_set_remote;
      kind = loop_pkg::net_line_loop;
    end else if (far_payload_set_code) begin
      op   = loop_pkg::op_set_remote;
      kind = loop_pkg::net_payload_loop;
    end else if (far_reset_code) begin
      op = loop_pkg::op_clr_remote;
    end
  end

  // loop and self-test next state
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    loop_next  = loop_reg;
    pass_next  = pass_reg;
    ram_next   = ram_reg;
    nv_next    = nv_reg;
    rom_next   = rom_reg;
    rej_next   = rej_reg;
    fl_next    = 1'b0;
    fp_next    = 1'b0;
    fr_next    = 1'b0;
    if (state_reg == loop_pkg::test_run) begin
      if (op != loop_pkg::op_none) begin
        rej_next = 1'b1;
      end
      // fixed test window, result at its end
      if (count_reg == 32'(SELF_TEST_CYCLES - 1)) begin
        state_next = loop_pkg::test_idle;
        count_next = 32'h0;
        ram_next  = ram_test_fail;
        nv_next   = nvram_test_fail;
        rom_next  = rom_checksum_fail;
        pass_next = !(ram_test_fail || nvram_test_fail || rom_checksum_fail);
      end else begin
        count_next = count_reg + 32'h1;
      end
    end else begin
      unique case (op)
        loop_pkg::op_none: ;
        loop_pkg::op_test: begin
          state_next = loop_pkg::test_run;
          count_next = 32'h0;
          loop_next  = loop_pkg::loop_none;
          pass_next  = 1'b0;
          rej_next   = 1'b0;
        end
        loop_pkg::op_denied: rej_next = 1'b1;
        loop_pkg::op_set, loop_pkg::op_set_remote: begin
          if ((loop_reg != loop_pkg::loop_none) ||
              ((far_kind || (op == loop_pkg::op_set_remote)) && !cbit)) begin
            rej_next = 1'b1;
          end else begin
            loop_next = kind;
            rej_next  = 1'b0;
            fl_next   = (kind == loop_pkg::far_line_loop);
            fp_next   = (kind == loop_pkg::far_payload_loop);
          end
        end
        loop_pkg::op_clr_local: begin
          rej_next = far_loop_active(loop_reg);
          if (!far_loop_active(loop_reg)) begin
            loop_next = loop_pkg::loop_none;
          end
        end
        loop_pkg::op_clr_far: begin
          rej_next = !cbit;
          fr_next  = cbit;
          if (cbit && far_loop_active(loop_reg)) begin
            loop_next = loop_pkg::loop_none;
          end
        end
        loop_pkg::op_clr_any: begin
          fr_next   = cbit && far_loop_active(loop_reg);
          loop_next = loop_pkg::loop_none;
          rej_next  = 1'b0;
        end
        loop_pkg::op_clr_remote: begin
          if (cbit && ((loop_reg == loop_pkg::net_line_loop) ||
                       (loop_reg == loop_pkg::net_payload_loop))) begin
            loop_next = loop_pkg::loop_none;
          end
        end
        default: rej_next = 1'b1;
      endcase
    end
  end

  function automatic logic far_loop_active(input loop_pkg::loop_e l);
    far_loop_active = (l == loop_pkg::far_line_loop) ||
                      (l == loop_pkg::far_payload_loop);
  endfunction

  always_comb begin
    ntx_next = normal_net_tx;
    trx_next = normal_term_rx;
    car_next = 1'b1;
    ais_next = ais_detect;
    unique case (loop_reg)
      loop_pkg::net_line_loop: begin
        ntx_next = net_rx_raw;
        trx_next = 1'b0;
        car_next = 1'b0;
      end
      loop_pkg::net_payload_loop: begin
        ntx_next = net_rx_framed;
        trx_next = 1'b0;
        car_next = 1'b0;
      end
      loop_pkg::terminal_framed_loop: begin
        ntx_next = term_framed_data;
        trx_next = term_framed_data;
      end
      loop_pkg::terminal_port_loop: trx_next = term_tx_data;
      default: ;
    endcase
    if (state_reg == loop_pkg::test_run) begin
      ntx_next = 1'b0;
      trx_next = 1'b0;
      car_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // power-up starts the self-test
      state_reg    <= loop_pkg::test_run;
      count_reg    <= 32'h0;
      loop_reg     <= loop_pkg::loop_none;
      pass_reg     <= 1'b0;
      ram_reg      <= 1'b0;
      nv_reg       <= 1'b0;
      rom_reg      <= 1'b0;
      rej_reg      <= 1'b0;
      fl_reg       <= 1'b0;
      fp_reg       <= 1'b0;
      fr_reg       <= 1'b0;
      wheel_s1_reg <= 4'h0;
      wheel_s2_reg <= 4'h0;
      ntx_reg      <= 1'b0;
      trx_reg      <= 1'b0;
      car_reg      <= 1'b0;
      ais_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      loop_reg     <= loop_next;
      pass_reg     <= pass_next;
      ram_reg      <= ram_next;
      nv_reg       <= nv_next;
      rom_reg      <= rom_next;
      rej_reg      <= rej_next;
      fl_reg       <= fl_next;
      fp_reg       <= fp_next;
      fr_reg       <= fr_next;
      wheel_s1_reg <= thumbwheel;
      wheel_s2_reg <= wheel_s1_reg;
      ntx_reg      <= ntx_next;
      trx_reg      <= trx_next;
      car_reg      <= car_next;
      ais_reg      <= ais_next;
    end
  end

  assign far_line_code_send    = fl_reg;
  assign far_payload_code_send = fp_reg;
  assign far_release_send      = fr_reg;
  assign net_tx_data           = ntx_reg;
  assign term_rx_data          = trx_reg;
  assign cts                   = car_reg;
  assign dcd                   = car_reg;
  assign service_halt          = (state_reg == loop_pkg::test_run);
  // lamp is green only after a pass
  assign status_green = (state_reg == loop_pkg::test_idle) && pass_reg;
  assign status_red   = !status_green;
  // alarm lamp also follows received all-ones
  assign ais_lamp = ram_reg || ais_reg;
  assign oof_lamp = nv_reg;
  assign los_lamp = rom_reg;
endmodule
`default_nettype wire

/* loop_ctrl_props.sv */
// assertions on the loop control ports
`timescale 1ns/1ns
`default_nettype none
module loop_ctrl_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read channel
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // line, carrier and lamps
  input wire logic far_line_code_send,
  input wire logic ais_detect,
  input wire logic ais_lamp,
  input wire logic cts,
  input wire logic dcd,
  input wire logic net_tx_data,
  input wire logic service_halt,
  input wire logic status_green
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_carrier_pair: assert property (cts == dcd)
    else $error("cts and dcd differ");
  a_test_span: assert property (
    $rose(service_halt) |-> service_halt[*8]) else $error("test too short");
  a_red_in_test: assert property (
    service_halt |-> !status_green) else $error("green during test");
  a_test_quiet: assert property (
    service_halt && $past(service_halt) |-> !cts && !net_tx_data)
    else $error("traffic during test");
  a_ais_follow: assert property (ais_detect |=> ais_lamp)
    else $error("ais lamp dark");
  a_far_pulse: assert property (
    far_line_code_send |=> !far_line_code_send) else $error("long pulse");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  c_far_send: cover property (far_line_code_send);
  c_pass: cover property ($rose(status_green));
  c_drop: cover property ($fell(cts) && !service_halt);
endmodule
bind loop_selftest_ctrl loop_ctrl_props i_loop_ctrl_props (.aclk, .aresetn,
  .arvalid, .arready, .rvalid, .far_line_code_send, .ais_detect, .ais_lamp,
  .cts, .dcd, .net_tx_data, .service_halt, .status_green);
`default_nettype wire

/* far_end_model.sv */
// far-end line model: received streams and loop codes
`timescale 1ns/1ns
`default_nettype none
module far_end_model (
  // clock, code to send (1 line, 2 payload, 3 release)
  input  wire logic       aclk,
  input  wire logic [1:0] code_req,
  // requests from the near unit, counted
  input  wire logic       far_line_code_send,
  input  wire logic       far_payload_code_send,
  input  wire logic       far_release_send,
  output int              heard,
  // received streams and codes
  output logic            net_rx_raw,
  output logic            net_rx_framed,
  output logic            far_line_set_code,
  output logic            far_payload_set_code,
  output logic            far_reset_code
);
  logic [7:0] pat = 8'h5a;
  logic [1:0] req_q = 2'h0;
  initial heard = 0;
  always @(posedge aclk) begin
    pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
    req_q <= code_req;
    heard <= heard + $countones({far_line_code_send, far_payload_code_send,
      far_release_send});
  end
  assign far_line_set_code = req_q == 2'h1;
  assign far_payload_set_code = req_q == 2'h2;
  assign far_reset_code = req_q == 2'h3;
  assign net_rx_raw = pat[0];
  assign net_rx_framed = pat[3];
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the loop and self-test control
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, got;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ais_detect = 1'b0;
  logic [3:0]  thumbwheel = 4'h0;
  logic        wheel_apply_button = 1'b0, ram_test_fail = 1'b0;
  logic        nvram_test_fail = 1'b0, rom_checksum_fail = 1'b0;
  logic        term_tx_data = 1'b0, term_framed_data = 1'b0;
  logic        normal_net_tx = 1'b0, normal_term_rx = 1'b0;
  logic [1:0]  code_req = 2'h0, resp, m_frame = 2'h0;
  logic        m_priv = 1'b0, m_rej = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, cts, dcd;
  wire logic   far_line_set_code, far_payload_set_code, far_reset_code;
  wire logic   far_line_code_send, far_payload_code_send, far_release_send;
  wire logic   net_rx_raw, net_rx_framed, net_tx_data, term_rx_data;
  wire logic   status_green, status_red, ais_lamp, oof_lamp, los_lamp;
  wire logic   service_halt;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          heard, bad_count = 0, n_compared = 0, m_loop = 0;
  int unsigned seed = 20003;
  loop_selftest_ctrl #(.SELF_TEST_CYCLES(20), .DEBOUNCE_CYCLES(4))
    i_loop_selftest_ctrl (.*, .wstrb(4'hf));
  far_end_model i_far_end_model (.*);
  always #20 aclk = ~aclk;
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    stop_test();
  endtask
  function automatic logic [3:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[3:0];
  endfunction
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) hang();
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) hang();
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic cfg(logic [5:0] v);
    wr(8'h04, {26'h0, v});
    m_frame = v[1:0];
    m_priv = v[4];
  endtask
  function automatic void model_cmd(int b);
    m_rej = 1'b1;
    if (!m_priv || (b == 1 && m_loop >= 5)) return;
    if (b inside {[2:4]} && m_frame != 2'h0) return;
    if (b inside {2, 3, [5:8]} && m_loop != 0) return;
    m_rej = 1'b0;
    m_loop = b >= 5 ? b - 4 : b inside {2, 3} ? b + 3 : 0;
  endfunction
  task automatic cmd(int b);
    model_cmd(b);
    wr(8'h00, 32'h1 << b);
    rd(8'h08);
    check("loop", m_loop, got[2:0]);
    check("refused", m_rej, got[8]);
  endtask
  task automatic press(logic [3:0] w);
    thumbwheel <= w;
    wheel_apply_button <= 1'b1;
    repeat (12) @(posedge aclk);
    wheel_apply_button <= 1'b0;
    repeat (12) @(posedge aclk);
    if (w == 4'h0) m_loop = 0;
    else model_cmd(w + 1);
    rd(8'h08);
    check("panel loop", m_loop, got[2:0]);
  endtask
  task automatic far_code(logic [1:0] v);
    code_req <= v;
    @(posedge aclk);
    code_req <= 2'h0;
    repeat (3) @(posedge aclk);
    if (m_frame == 2'h0 && v == 2'h3 && m_loop inside {1, 2}) m_loop = 0;
    if (m_frame == 2'h0 && v != 2'h3 && m_loop == 0) m_loop = v;
    rd(8'h08);
    check("far code loop", m_loop, got[2:0]);
  endtask
  task automatic streams(int c);
    logic [5:0] p;
    logic en, et;
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      {term_tx_data, term_framed_data, normal_net_tx, normal_term_rx} <= rnd();
      @(negedge aclk);
      en = c == 1 ? p[5] : c == 2 ? p[4] : c == 3 ? p[2] : p[1];
      et = c inside {1, 2} ? 1'b0 : c == 3 ? p[2] : c == 4 ? p[3] : p[0];
      if (i > 0) check("net_tx", en, net_tx_data);
      if (i > 0) check("term_rx", et, term_rx_data);
      if (i > 0) check("cts", !(c inside {1, 2}), cts);
      p = {net_rx_raw, net_rx_framed, term_tx_data, term_framed_data,
           normal_net_tx, normal_term_rx};
    end
  endtask
  task automatic wait_test();
    int n;
    for (n = 0; n < 40 && (n == 0 || got[3]); n++) rd(8'h08);
    if (n == 40) hang();
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_test();
    check("pass", 1, got[4]);
    cfg(6'h10);
    rd(8'h04);
    check("cfg", 32'h10, got);
    cmd(5);
    cmd(6);
    streams(1);
    cmd(1);
    for (int b = 6; b < 9; b++) begin
      cmd(b);
      streams(b - 4);
      cmd(1);
    end
    cmd(2);
    cmd(1);
    cmd(4);
    cmd(3);
    cmd(4);
    far_code(2'h1);
    far_code(2'h3);
    far_code(2'h2);
    far_code(2'h3);
    cfg(6'h11);
    far_code(2'h1);
    cmd(2);
    cfg(6'h10);
    thumbwheel <= 4'h4;
    repeat (12) @(posedge aclk);
    rd(8'h08);
    check("wheel alone", 0, got[2:0]);
    for (int w = 4; w < 8; w++) begin
      press(w[3:0]);
      press(4'h5);
      press(4'h0);
    end
    press(4'h2);
    press(4'h0);
    press(4'h1);
    press(4'h0);
    check("far sends", 8, heard);
    cfg(6'h00);
    cmd(5);
    cfg(6'h10);
    cmd(5);
    for (int k = 0; k < 4; k++) begin
      {ram_test_fail, nvram_test_fail, rom_checksum_fail} <= 3'b100 >> k;
      cmd(0);
      wait_test();
      check("fail lamps", 3'b100 >> k, {ais_lamp, oof_lamp, los_lamp});
      check("red", k < 3, status_red);
    end
    ais_detect <= 1'b1;
    repeat (3) @(posedge aclk);
    check("ais lamp", 1, ais_lamp);
    rd(8'h0c);
    check("unmapped resp", 2'h2, resp);
    stop_test();
  end
endmodule
`default_nettype wire
